/* hw/dmx_exec.sv */
/*
  Execution unit for the data-move instruction group. One instruction is
  taken per cycle on insn_valid; data memory reads return combinationally
  on mem_rdata. Registers are visible over Avalon-MM with waitrequest.
*/
`timescale 1ns/100ps
`default_nettype none
module dmx_exec (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        insn_valid,
  input  wire logic [13:0] insn,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic [15:0]      rd_addr,
  output logic             zero_flag,
  output logic             insn_done,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  logic        is_movi;
  logic        is_movik;
  logic        is_lb;
  logic        is_lp;
  logic        is_lw;
  logic        is_wf;
  logic        ptr_sel;
  logic [1:0]  upd_mode;
  logic [5:0]  ofs_k;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic [15:0] eff_addr;
  logic [15:0] new_ptr;
  logic [7:0]  working;
  logic [4:0]  bank_select_reg;
  logic [6:0]  pc_high_latch;
  logic        ack;
  logic [15:0] wf_addr;
  logic        ind_move;
  logic [15:0] cur_ptr;

  dmx_decode u_dec (
    .insn     (insn),
    .is_movi  (is_movi),
    .is_movik (is_movik),
    .is_lb    (is_lb),
    .is_lp    (is_lp),
    .is_lw    (is_lw),
    .is_wf    (is_wf),
    .ptr_sel  (ptr_sel),
    .upd_mode (upd_mode),
    .ofs_k    (ofs_k)
  );

  dmx_ptr_upd u_ptr (
    .ptr         (cur_ptr),
    .mode        (upd_mode),
    .offset_form (is_movik),
    .ofs_k       (ofs_k),
    .eff_addr    (eff_addr),
    .new_ptr     (new_ptr)
  );

  // Map a banked file address to a linear one, redirecting window regs
  function automatic logic [15:0] file_addr(input logic [6:0] f, input logic [4:0] b,
                                             input logic [15:0] p0, input logic [15:0] p1);
    if (f == dmx_pkg::IND0_ADDR)
      file_addr = p0;
    else if (f == dmx_pkg::IND1_ADDR)
      file_addr = p1;
    else
      file_addr = {4'h0, b, f};
  endfunction

  // Pointer named by the select bit of the current word
  function automatic logic [15:0] pick_ptr(input logic sel, input logic [15:0] p0, input logic [15:0] p1);
    pick_ptr = sel ? p1 : p0;
  endfunction

  // Address lookups shared by memory outputs
  always_comb begin
    ind_move = insn_valid && (is_movi || is_movik);
    wf_addr  = file_addr(insn[6:0], bank_select_reg, ptr0, ptr1);
    rd_addr  = eff_addr; // Read address for indirect load
    cur_ptr  = pick_ptr(ptr_sel, ptr0, ptr1);
    ack      = (avs_read || avs_write) && !avs_waitrequest; // Request taken at this edge
  end

  // Working register: literal load or indirect load
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      working <= dmx_pkg::WORK_RST;
    end else if (avs_write && ack && avs_address == dmx_pkg::REG_WORK) begin
      working <= avs_writedata[7:0];
    end else if (insn_valid && is_lw) begin
      working <= insn[7:0];
    end else if (ind_move) begin
      working <= mem_rdata;
    end
  end

  // Zero flag only touched by indirect load
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      zero_flag <= 1'b0;
    end else if (ind_move) begin
      zero_flag <= (mem_rdata == 8'h00);
    end
  end

  // Bank select register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bank_select_reg <= 5'h00;
    end else if (avs_write && ack && avs_address == dmx_pkg::REG_BANK) begin
      bank_select_reg <= avs_writedata[4:0] & dmx_pkg::BANK_MAX;
    end else if (insn_valid && is_lb) begin
      bank_select_reg <= insn[4:0] & dmx_pkg::BANK_MAX;
    end
  end

  // Program counter high latch
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pc_high_latch <= 7'h00;
    end else if (avs_write && ack && avs_address == dmx_pkg::REG_PC_LATCH) begin
      pc_high_latch <= avs_writedata[6:0];
    end else if (insn_valid && is_lp) begin
      pc_high_latch <= insn[6:0];
    end
  end

  // File select pointers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ptr0 <= dmx_pkg::PTR_RST;
      ptr1 <= dmx_pkg::PTR_RST;
    end else if (avs_write && ack && avs_address == dmx_pkg::REG_PTR0) begin
      ptr0 <= avs_writedata[15:0];
      ptr1 <= avs_writedata[31:16];
    end else if (ind_move) begin
      if (ptr_sel)
        ptr1 <= new_ptr;
      else
        ptr0 <= new_ptr;
    end
  end

  // Store working to file in one cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mem_we    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 8'h00;
      insn_done <= 1'b0;
    end else begin
      mem_we    <= insn_valid && is_wf;
      mem_addr  <= wf_addr;
      mem_wdata <= working;
      insn_done <= insn_valid;
    end
  end

  // Avalon slave: registered waitrequest, low for one cycle per request
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          dmx_pkg::REG_WORK:     avs_readdata <= {24'h000000, working};
          dmx_pkg::REG_BANK:     avs_readdata <= {27'h0000000, bank_select_reg};
          dmx_pkg::REG_PC_LATCH: avs_readdata <= {25'h0000000, pc_high_latch};
          dmx_pkg::REG_PTR0:   avs_readdata <= {ptr1, ptr0};
          default:             avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  wf_cycle_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_wf |=> mem_we && mem_wdata == $past(working)) else $error("store late");
  lw_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_lw && !avs_write |=> working == $past(insn[7:0])) else $error("literal load");
  lw_flags_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_lw |=> $stable(zero_flag)) else $error("flag changed");
  lb_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_lb && !avs_write |=> bank_select_reg == {1'b0, $past(insn[3:0])}) else $error("bank");
  lp_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_lp && !avs_write |=> pc_high_latch == $past(insn[6:0])) else $error("latch");
  ptr_preinc_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movi && !ptr_sel && upd_mode == dmx_pkg::MODE_PREINC && !avs_write
    |=> ptr0 == $past(ptr0) + 16'h0001) else $error("preinc");
  ptr_offset_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movik && !avs_write |=> $stable(ptr0) && $stable(ptr1)) else $error("offset");
  post_addr_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movi && upd_mode[1] |-> rd_addr == (ptr_sel ? ptr1 : ptr0)) else $error("post");
  ind_redir_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_wf && insn[6:0] == dmx_pkg::IND0_ADDR |=> mem_addr == $past(ptr0)) else $error("window");
  ptr_wrap_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movi && !ptr_sel && upd_mode == dmx_pkg::MODE_PREDEC && ptr0 == 16'h0000 && !avs_write
    |=> ptr0 == 16'hffff) else $error("wrap");

  // Pre-increment on either pointer
  ptr_preinc_sel_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movi && upd_mode == dmx_pkg::MODE_PREINC && !avs_write
    |=> ($past(ptr_sel) ? ptr1 : ptr0) == $past(cur_ptr) + 16'h0001) else $error("preinc sel");

  // Pre-decrement steps the pointer down
  ptr_predec_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movi && upd_mode == dmx_pkg::MODE_PREDEC && !avs_write
    |=> ($past(ptr_sel) ? ptr1 : ptr0) == $past(cur_ptr) - 16'h0001) else $error("predec");

  // Post-increment steps the pointer up
  ptr_postinc_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movi && upd_mode == dmx_pkg::MODE_POSTINC && !avs_write
    |=> ($past(ptr_sel) ? ptr1 : ptr0) == $past(cur_ptr) + 16'h0001) else $error("postinc");

  // Post-decrement steps the pointer down
  ptr_postdec_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movi && upd_mode == dmx_pkg::MODE_POSTDEC && !avs_write
    |=> ($past(ptr_sel) ? ptr1 : ptr0) == $past(cur_ptr) - 16'h0001) else $error("postdec");

  // Pre modes read at the already stepped address
  pre_addr_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movi && !upd_mode[1]
    |-> rd_addr == (upd_mode[0] ? cur_ptr - 16'h0001 : cur_ptr + 16'h0001)) else $error("pre");

  // The pointer not selected keeps its value
  other_ptr_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && !avs_write
    |=> $past(ptr_sel) ? $stable(ptr0) : $stable(ptr1)) else $error("other pointer");

  // Indirect load lands in working and sets the zero flag
  ind_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && !avs_write
    |=> working == $past(mem_rdata) && zero_flag == ($past(mem_rdata) == 8'h00)) else $error("ind load");

  // Second window register goes to the second pointer
  ind1_redir_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_wf && insn[6:0] == dmx_pkg::IND1_ADDR
    |=> mem_addr == $past(ptr1)) else $error("window 1");

  // Plain store address is bank and operand
  wf_bank_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_wf && insn[6:0] > dmx_pkg::IND1_ADDR
    |=> mem_addr == {4'h0, $past(bank_select_reg), $past(insn[6:0])}) else $error("store addr");

  // Offset form reads at pointer plus signed literal
  ofs_addr_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movik
    |-> rd_addr == cur_ptr + {{10{ofs_k[5]}}, ofs_k}) else $error("offset addr");

  // Increment past the top wraps to zero
  ptr_wrap_up_a: assert property (@(posedge clock) disable iff (sys_rst)
    ind_move && is_movi && upd_mode == dmx_pkg::MODE_POSTINC && cur_ptr == 16'hffff && !avs_write
    |=> ($past(ptr_sel) ? ptr1 : ptr0) == 16'h0000) else $error("wrap up");

  // Store leaves flag and working alone
  wf_flags_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_wf && !avs_write
    |=> $stable(zero_flag) && $stable(working)) else $error("store side");

  // Every instruction completes in one cycle
  insn_done_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid |=> insn_done) else $error("done");

  // Write strobe only after a store
  wf_pulse_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(insn_valid && is_wf) |=> !mem_we) else $error("store pulse");

  // Literal load touches nothing but working
  lw_other_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_lw && !avs_write
    |=> $stable(bank_select_reg) && $stable(pc_high_latch) && $stable(ptr0) && $stable(ptr1)) else $error("lw side");

  // Bank literal leaves the flag alone
  lb_flags_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_lb |=> $stable(zero_flag)) else $error("bank flag");

  // Latch literal leaves the flag alone
  lp_flags_a: assert property (@(posedge clock) disable iff (sys_rst)
    insn_valid && is_lp |=> $stable(zero_flag)) else $error("latch flag");

  // First cycle of a fresh request always waits
  bus_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
    (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest) else $error("bus wait");

  // Pointer write lands at the taken edge
  bus_ptr_a: assert property (@(posedge clock) disable iff (sys_rst)
    avs_write && ack && avs_address == dmx_pkg::REG_PTR0
    |=> {ptr1, ptr0} == $past(avs_writedata)) else $error("bus pointer");

  // Waitrequest low for a single cycle only
  bus_once_a: assert property (@(posedge clock) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest) else $error("bus once");

  wf_seen_c: cover property (@(posedge clock) insn_valid && is_wf);
  wrap_seen_c: cover property (@(posedge clock) ind_move && ptr0 == 16'hffff);
  offset_seen_c: cover property (@(posedge clock) ind_move && is_movik);
  bus_read_c: cover property (@(posedge clock) avs_read && !avs_waitrequest);
  bus_write_c: cover property (@(posedge clock) avs_write && !avs_waitrequest);
endmodule
`default_nettype wire

/* hw/dmx_pkg.sv */
/*
  Constants for the data-move execution block: instruction encodings,
  pointer update modes, register offsets, widths and reset values.
  Assumes a 14-bit instruction word and a 16-bit data address space.
*/
package dmx_pkg;
  // Instruction and data address widths
  localparam int unsigned INSN_W = 14;
  localparam int unsigned ADDR_W = 16;

  // Pointer update modes
  localparam logic [1:0] MODE_PREINC  = 2'h0;
  localparam logic [1:0] MODE_PREDEC  = 2'h1;
  localparam logic [1:0] MODE_POSTINC = 2'h2;
  localparam logic [1:0] MODE_POSTDEC = 2'h3;

  // Opcode patterns and masks
  localparam logic [13:0] OPC_MOVI_MASK = 14'h3ff8;
  localparam logic [13:0] OPC_MOVI      = 14'h0010;
  localparam logic [13:0] OPC_MOVIK_MSK = 14'h3f80;
  localparam logic [13:0] OPC_MOVIK     = 14'h3f00;
  localparam logic [13:0] OPC_LB_MASK   = 14'h3fe0;
  localparam logic [13:0] OPC_LB        = 14'h0020;
  localparam logic [13:0] OPC_LP_MASK   = 14'h3f80;
  localparam logic [13:0] OPC_LP        = 14'h3180;
  localparam logic [13:0] OPC_LW_MASK   = 14'h3f00;
  localparam logic [13:0] OPC_LW        = 14'h3000;
  localparam logic [13:0] OPC_WF_MASK   = 14'h3f80;
  localparam logic [13:0] OPC_WF        = 14'h0080;

  // Field positions
  localparam int unsigned PTR_SEL_BIT = 2;
  localparam int unsigned OFS_PTR_BIT = 6;
  localparam int unsigned BANK_W      = 5;
  localparam logic [4:0]  BANK_MAX    = 5'h0f;

  // Indirect window register addresses within a bank
  localparam logic [6:0] IND0_ADDR = 7'h00;
  localparam logic [6:0] IND1_ADDR = 7'h01;

  // Avalon register offsets (byte addresses)
  localparam logic [3:0] REG_WORK   = 4'h0;
  localparam logic [3:0] REG_BANK   = 4'h4;
  localparam logic [3:0] REG_PC_LATCH = 4'h8;
  localparam logic [3:0] REG_PTR0   = 4'hc;

  // Reset values
  localparam logic [7:0]  WORK_RST = 8'h00;
  localparam logic [15:0] PTR_RST  = 16'h0000;
endpackage

/* hw/dmx_decode.sv */
/*
  Instruction decoder for the data-move group: classifies a word and
  extracts operands. Purely combinational; the caller registers results.
*/
`timescale 1ns/100ps
`default_nettype none
module dmx_decode (
  input  wire logic [13:0] insn,
  output logic             is_movi,
  output logic             is_movik,
  output logic             is_lb,
  output logic             is_lp,
  output logic             is_lw,
  output logic             is_wf,
  output logic             ptr_sel,
  output logic [1:0]       upd_mode,
  output logic [5:0]       ofs_k
);
  // Pattern match on masked opcode
  always_comb begin
    is_movi  = (insn & dmx_pkg::OPC_MOVI_MASK) == dmx_pkg::OPC_MOVI;
    is_movik = (insn & dmx_pkg::OPC_MOVIK_MSK) == dmx_pkg::OPC_MOVIK;
    is_lb    = (insn & dmx_pkg::OPC_LB_MASK) == dmx_pkg::OPC_LB;
    is_lp    = (insn & dmx_pkg::OPC_LP_MASK) == dmx_pkg::OPC_LP;
    is_lw    = (insn & dmx_pkg::OPC_LW_MASK) == dmx_pkg::OPC_LW;
    is_wf    = (insn & dmx_pkg::OPC_WF_MASK) == dmx_pkg::OPC_WF;
    ptr_sel  = is_movik ? insn[dmx_pkg::OFS_PTR_BIT] : insn[dmx_pkg::PTR_SEL_BIT];
    upd_mode = insn[1:0];
    ofs_k    = insn[5:0];
  end
endmodule
`default_nettype wire

/* hw/dmx_ptr_upd.sv */
/*
  Pointer arithmetic for the indirect move: effective address and
  written-back pointer for each update mode and the offset form.
*/
`timescale 1ns/100ps
`default_nettype none
module dmx_ptr_upd (
  input  wire logic [15:0] ptr,
  input  wire logic [1:0]  mode,
  input  wire logic        offset_form,
  input  wire logic [5:0]  ofs_k,
  output logic [15:0]      eff_addr,
  output logic [15:0]      new_ptr
);
  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] sext;
  // Plus/minus one wrap naturally in 16 bits
  always_comb begin
    inc  = ptr + 16'h0001;
    dec  = ptr - 16'h0001;
    sext = {{10{ofs_k[5]}}, ofs_k};
    if (offset_form) begin
      eff_addr = ptr + sext;
      new_ptr  = ptr;
    end else begin
      case (mode)
        dmx_pkg::MODE_PREINC: begin
          eff_addr = inc;
          new_ptr  = inc;
        end
        dmx_pkg::MODE_PREDEC: begin
          eff_addr = dec;
          new_ptr  = dec;
        end
        dmx_pkg::MODE_POSTINC: begin
          eff_addr = ptr;
          new_ptr  = inc;
        end
        default: begin
          eff_addr = ptr;
          new_ptr  = dec;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* verification/test_data_move_instruction_exec.sv */
/*
  Self-checking bench for the data-move execution unit: literal loads,
  store of working, indirect moves with pointer update, offset form.
  Assumes the Avalon slave answers within the bench's bus timeout.
*/
`timescale 1ns/100ps
`default_nettype none
module test_data_move_instruction_exec;
  logic        clock;
  logic        sys_rst;
  logic        insn_valid;
  logic [13:0] insn;
  logic [7:0]  mem_rdata;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic        mem_we;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [15:0] rd_addr;
  logic        zero_flag;
  logic        insn_done;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          n_mismatch;
  int          compares;
  int          it;
  logic [31:0] rd;
  logic [15:0] ra;
  logic [15:0] p0;
  logic [15:0] p1;
  logic [15:0] q;
  logic [15:0] q2;
  logic [7:0]  w;
  logic [7:0]  d;
  logic [4:0]  bk;
  logic [6:0]  f;
  logic [5:0]  k;
  logic [1:0]  m;
  logic        n;
  logic        z;

  dmx_exec i_dut (
    .clock           (clock),
    .sys_rst         (sys_rst),
    .insn_valid      (insn_valid),
    .insn            (insn),
    .mem_we          (mem_we),
    .mem_addr        (mem_addr),
    .mem_wdata       (mem_wdata),
    .mem_rdata       (mem_rdata),
    .rd_addr         (rd_addr),
    .zero_flag       (zero_flag),
    .insn_done       (insn_done),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest)
  );

  // Free-running clock, 50 ns period
  initial clock = 1'b0;
  always #25 clock = ~clock;

  // Verdict and end of run
  task automatic results();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Single compare point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int i;
    @(posedge clock);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_mismatch++;
      results();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // One instruction cycle; read address captured mid-cycle
  task automatic run(input logic [13:0] word, input logic [7:0] rdat);
    @(posedge clock);
    insn_valid <= 1'b1;
    insn <= word;
    mem_rdata <= rdat;
    @(negedge clock);
    ra = rd_addr;
    @(posedge clock);
    insn_valid <= 1'b0;
    mem_rdata <= ~rdat;
    @(negedge clock);
  endtask

  // Expected effective address and written-back pointer
  function automatic logic [15:0] eff(input logic [15:0] p, input logic [1:0] md);
    case (md)
      2'h0: return p + 16'h0001;
      2'h1: return p - 16'h0001;
      default: return p;
    endcase
  endfunction

  function automatic logic [15:0] upd(input logic [15:0] p, input logic [1:0] md);
    return md[0] ? p - 16'h0001 : p + 16'h0001;
  endfunction

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    insn_valid = 1'b0;
    insn = 14'h0000;
    mem_rdata = 8'h00;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    n_mismatch = 0;
    compares = 0;
    void'($urandom(32'h3fb1c8e2));
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    // Reset values and an unmapped place
    bus(1'b0, dmx_pkg::REG_WORK, 32'h0);
    chk(32'(rd[7:0]), 32'(dmx_pkg::WORK_RST));
    bus(1'b0, dmx_pkg::REG_PTR0, 32'h0);
    chk(rd, {dmx_pkg::PTR_RST, dmx_pkg::PTR_RST});
    bus(1'b1, 4'h2, 32'hffffffff);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    for (it = 0; it < 16; it++) begin
      w = 8'($urandom);
      d = (it == 1) ? 8'h00 : 8'($urandom);
      bk = (it == 0) ? 5'h0f : 5'($urandom_range(15));
      f = (it == 0) ? 7'h7f : 7'($urandom_range(127, 2));
      k = (it == 2) ? 6'h20 : (it == 3) ? 6'h1f : 6'($urandom);
      m = it[1:0];
      n = it[2];
      p0 = (it < 8) ? 16'hffff : (it == 9) ? 16'h0000 : 16'($urandom);
      p1 = (it < 8) ? 16'h0000 : 16'($urandom);
      // Literal loads leave the zero flag alone
      z = zero_flag;
      run(14'h3000 | 14'(w), d);
      bus(1'b0, dmx_pkg::REG_WORK, 32'h0);
      chk(32'(rd[7:0]), 32'(w));
      chk(32'(zero_flag), 32'(z));
      run(14'h0020 | 14'(bk), d);
      bus(1'b0, dmx_pkg::REG_BANK, 32'h0);
      chk(32'(rd[4:0]), 32'(bk));
      run(14'h3180 | 14'(f), d);
      bus(1'b0, dmx_pkg::REG_PC_LATCH, 32'h0);
      chk(32'(rd[6:0]), 32'(f));
      // Store of working into a banked file register
      run(14'h0080 | 14'(f), d);
      chk(32'(mem_we), 32'h1);
      chk(32'(mem_addr), 32'({bk, f}));
      chk(32'(mem_wdata), 32'(w));
      chk(32'(zero_flag), 32'(z));
      chk(32'(insn_done), 32'h1);
      @(negedge clock);
      chk(32'(mem_we), 32'h0);
      chk(32'(insn_done), 32'h0);
      // Indirect move with pointer update and wrap
      bus(1'b1, dmx_pkg::REG_PTR0, {p1, p0});
      q = n ? p1 : p0;
      q2 = upd(q, m);
      run(14'h0010 | 14'({n, m}), d);
      chk(32'(ra), 32'(eff(q, m)));
      bus(1'b0, dmx_pkg::REG_PTR0, 32'h0);
      chk(rd, n ? {q2, p0} : {p1, q2});
      bus(1'b0, dmx_pkg::REG_WORK, 32'h0);
      chk(32'(rd[7:0]), 32'(d));
      chk(32'(zero_flag), 32'(d == 8'h00));
      // Window register store goes to the pointer address
      run(14'h0080 | 14'(n), d);
      chk(32'(mem_addr), 32'(q2));
      chk(32'(mem_wdata), 32'(d));
      // Offset form leaves the pointer unchanged
      run(14'h3f00 | 14'({n, k}), d);
      q = q2 + {{10{k[5]}}, k};
      chk(32'(ra), 32'(q));
      bus(1'b0, dmx_pkg::REG_PTR0, 32'h0);
      chk(rd, n ? {q2, p0} : {p1, q2});
    end
    results();
  end
endmodule
`default_nettype wire
